// ==== spm_monitor.sv ====
// Short-window power monitor top: registers, gate control, alarm mask.
// Assumes one register access per clock on the byte port; page
// select comes from the paging register held elsewhere in the chip.
`timescale 1ns/1ns

// Function
// R1 - Control bit 7 turns averaging and threshold checking on; off otherwise.
// R2 - Window holds two to the power of the length field detector ticks.
// R3 - Main interpolation above one: tick period is four times main factor.
// R4 - Else channel interpolation above one: period is eight times main factor.
// R5 - Otherwise the tick period is thirty-two converter clocks.
// R6 - Power is I squared plus Q squared from six top bits.
// R7 - Averaged power reads back as 13 bits over low and high bytes.
// R8 - Writable 13-bit threshold, upper five bits in its own register.
// R9 - Every control here follows the main converter page select.
// R10 - Transmit state machine enable is bit 0, reset to off.
// R11 - Blanking bit 2 hands the transmit gate to the register port.
// R12 - Under override, gate status equals blanking bit 3.
// R13 - Each alarm mask bit enables one link power-protection alarm.
// R14 - Nine alarm enables map sync, checksum, error and FIFO sources.
// R15 - Average above threshold while enabled raises a power error flag.
module spm_monitor #(
	parameter int PAGE_INDEX = 0,
	parameter int PAGE_COUNT = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire spm_pkg::spm_reg_req_s reg_req,
	input wire logic [PAGE_COUNT-1:0] main_converter_page_select,
	output logic [7:0] reg_rdata,
	// Datapath settings and samples
	input wire logic [spm_pkg::SPM_INTERP_W-1:0] main_interp,
	input wire logic [spm_pkg::SPM_INTERP_W-1:0] chan_interp,
	input wire spm_pkg::spm_iq_s sample,
	// Transmit gate
	input wire logic transmit_gate_input,
	output logic transmit_gate_status,
	output logic transmit_enable,
	output logic short_power_error,
	// Link alarms
	input wire logic [spm_pkg::SPM_ALARM_W-1:0] link_alarm_src,
	output logic link_alarm_irq
);
	import spm_pkg::*;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (PAGE_INDEX < 0 || PAGE_INDEX >= PAGE_COUNT) begin : g_bad_page
		$error("PAGE_INDEX outside page select width");
	end
	if (PAGE_COUNT < 1) begin : g_bad_count
		$error("PAGE_COUNT must be at least one");
	end

	// Field layout below assumes these widths; refuse anything else
	if (SPM_POWER_W != 8 + SPM_HIGH_W) begin : g_bad_power_w
		$error("power width must fill the low byte and the high field");
	end
	if (SPM_ALARM_W != 9) begin : g_bad_alarm_w
		$error("alarm mask must be eight low bits plus one");
	end
	if (SPM_CTRL_ENABLE_BIT < SPM_LEN_W || SPM_CTRL_ENABLE_BIT > 7) begin : g_bad_ctrl
		$error("enable bit overlaps the length field");
	end
	if (SPM_SOFT_VALUE_BIT == SPM_SOFT_OVERRIDE_BIT) begin : g_bad_blank
		$error("soft gate value and override share a bit");
	end
	if (SPM_SOFT_VALUE_BIT > 7 || SPM_SOFT_OVERRIDE_BIT > 7) begin : g_bad_blank_pos
		$error("soft gate bits outside the byte");
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] limit_low_q;
	logic [SPM_HIGH_W-1:0] limit_high_q;
	logic short_power_calc_enable_q;
	logic [SPM_LEN_W-1:0] short_window_length_q;
	logic transmit_gate_fsm_enable_q;
	logic soft_transmit_gate_value_q;
	logic soft_transmit_gate_override_q;
	logic [SPM_ALARM_W-1:0] link_alarm_irq_mask_q;
	logic [SPM_POWER_W-1:0] short_power_readback_q;
	logic short_power_error_q;
	logic [7:0] rdata_q;
	logic link_alarm_irq_q;
	spm_tx_state_e tx_state_q;
	spm_tx_state_e tx_state_d;

	logic page_hit;
	logic wr;
	logic tick;
	logic [SPM_POWER_W-1:0] avg_power;
	logic avg_done;
	logic [SPM_POWER_W-1:0] short_power_limit;
	logic gate_status;

	// Write strobe decode against one offset
	function automatic logic hit(input spm_reg_req_s req, input logic [11:0] addr);
		hit = req.write && (req.addr == addr);
	endfunction

	// ----------------------------------------
	// Paging
	// ----------------------------------------

	// Accesses count only when this converter's page is selected.
	// Several converters share one port and one address map; each
	// instance looks at its own select bit, so more than one bit may
	// be set and a write then reaches every selected converter.
	assign page_hit = main_converter_page_select[PAGE_INDEX]; // see R9
	assign wr = page_hit && reg_req.write; // see R9
	assign short_power_limit = {limit_high_q, limit_low_q};

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------

	// Threshold bytes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			limit_low_q <= SPM_RESET_BYTE;
			limit_high_q <= '0;
		end else if (wr) begin
			if (hit(reg_req, SPM_ADDR_LIMIT_LOW)) begin
				limit_low_q <= reg_req.wdata; // see R8
			end
			if (hit(reg_req, SPM_ADDR_LIMIT_HIGH)) begin
				limit_high_q <= reg_req.wdata[SPM_HIGH_W-1:0]; // see R8
			end
		end
	end

	// Detector control
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			short_power_calc_enable_q <= 1'b0;
			short_window_length_q <= '0;
		end else if (wr && hit(reg_req, SPM_ADDR_CONTROL)) begin
			short_power_calc_enable_q <= reg_req.wdata[SPM_CTRL_ENABLE_BIT]; // see R1
			short_window_length_q <= reg_req.wdata[SPM_LEN_W-1:0]; // see R2
		end
	end

	// Transmit state machine enable
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			transmit_gate_fsm_enable_q <= 1'b0; // see R10
		end else if (wr && hit(reg_req, SPM_ADDR_TX_FSM)) begin
			transmit_gate_fsm_enable_q <= reg_req.wdata[SPM_TX_FSM_ENABLE_BIT]; // see R10
		end
	end

	// Blanking control, soft gate override
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			soft_transmit_gate_value_q <= 1'b0;
			soft_transmit_gate_override_q <= 1'b0;
		end else if (wr && hit(reg_req, SPM_ADDR_BLANKING)) begin
			soft_transmit_gate_value_q <= reg_req.wdata[SPM_SOFT_VALUE_BIT]; // see R12
			soft_transmit_gate_override_q <= reg_req.wdata[SPM_SOFT_OVERRIDE_BIT]; // see R11
		end
	end

	// Link alarm mask, eight low bits plus bit 8
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link_alarm_irq_mask_q <= '0;
		end else if (wr) begin
			if (hit(reg_req, SPM_ADDR_MASK_LOW)) begin
				link_alarm_irq_mask_q[7:0] <= reg_req.wdata; // see R13
			end
			if (hit(reg_req, SPM_ADDR_MASK_HIGH)) begin
				link_alarm_irq_mask_q[8] <= reg_req.wdata[0]; // see R14
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------

	// Registered read data, reserved bits and unknown offsets read zero.
	// Data stands until the next paged read, so an unpaged read leaves
	// the previous byte visible rather than a stale mix.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= SPM_RESET_BYTE;
		end else if (reg_req.read && page_hit) begin
			case (reg_req.addr)
				SPM_ADDR_LIMIT_LOW: rdata_q <= limit_low_q;
				SPM_ADDR_LIMIT_HIGH: rdata_q <= {3'h0, limit_high_q};
				SPM_ADDR_CONTROL: rdata_q <= {short_power_calc_enable_q, 5'h00, short_window_length_q};
				SPM_ADDR_RESULT_LOW: rdata_q <= short_power_readback_q[7:0]; // see R7
				SPM_ADDR_RESULT_HIGH: rdata_q <= {3'h0, short_power_readback_q[12:8]}; // see R7
				SPM_ADDR_TX_FSM: rdata_q <= {7'h00, transmit_gate_fsm_enable_q};
				SPM_ADDR_BLANKING: rdata_q <= {4'h0, soft_transmit_gate_value_q,
					soft_transmit_gate_override_q, 2'h0};
				SPM_ADDR_MASK_LOW: rdata_q <= link_alarm_irq_mask_q[7:0];
				SPM_ADDR_MASK_HIGH: rdata_q <= {7'h00, link_alarm_irq_mask_q[8]};
				default: rdata_q <= SPM_UNMAPPED_BYTE;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Short-window detector
	// ----------------------------------------

	// Tick source, held idle while detection is off.
	// Interpolation settings are meant to be static while running; a
	// change mid-window only bends that one window, the next is clean.
	spm_tick_gen u_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(short_power_calc_enable_q), // see R1
		.main_interp(main_interp),
		.chan_interp(chan_interp),
		.tick(tick)
	);

	// Squaring and averaging
	spm_power_avg u_avg (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(short_power_calc_enable_q), // see R1
		.tick(tick),
		.win_len(short_window_length_q),
		.sample(sample),
		.avg_power(avg_power),
		.avg_done(avg_done)
	);

	// Readback holds the last completed average.
	// Both bytes come from one register, but software reading low then
	// high may straddle a window end; read twice if that matters.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			short_power_readback_q <= '0;
		end else if (avg_done) begin
			short_power_readback_q <= avg_power; // see R7
		end
	end

	// Error flag judged at each window end, cleared when disabled.
	// Not sticky: a later quiet window drops it again, so any consumer
	// that needs history must latch it itself.
	always_ff @(posedge mclk) begin
		if (!rst_n || !short_power_calc_enable_q) begin
			short_power_error_q <= 1'b0; // see R1
		end else if (avg_done) begin
			short_power_error_q <= avg_power > short_power_limit; // see R15
		end
	end

	assign short_power_error = short_power_error_q;

	// ----------------------------------------
	// Transmit gate
	// ----------------------------------------

	// Gate status from pin or from the soft override
	assign gate_status = soft_transmit_gate_override_q ? soft_transmit_gate_value_q // see R12
		: transmit_gate_input; // see R11
	assign transmit_gate_status = gate_status;

	// Next state: a power error blocks output until the gate drops.
	// Blocking holds until the gate status falls, so a power burst
	// cannot leak through by the error clearing on its own; the
	// transmitter must be re-armed by a fresh gate pulse.
	always_comb begin
		case (tx_state_q)
			SPM_TX_IDLE: tx_state_d = gate_status ? SPM_TX_ACTIVE : SPM_TX_IDLE;
			SPM_TX_ACTIVE: begin
				if (!gate_status) begin
					tx_state_d = SPM_TX_IDLE;
				end else if (short_power_error_q) begin
					tx_state_d = SPM_TX_BLOCKED; // see R15
				end else begin
					tx_state_d = SPM_TX_ACTIVE;
				end
			end
			SPM_TX_BLOCKED: tx_state_d = gate_status ? SPM_TX_BLOCKED : SPM_TX_IDLE;
			default: tx_state_d = SPM_TX_IDLE;
		endcase
	end

	// State register, parked idle while the machine is disabled
	always_ff @(posedge mclk) begin
		if (!rst_n || !transmit_gate_fsm_enable_q) begin
			tx_state_q <= SPM_TX_IDLE; // see R10
		end else begin
			tx_state_q <= tx_state_d;
		end
	end

	// Enable follows the machine, or the gate directly when disabled
	assign transmit_enable = transmit_gate_fsm_enable_q ? (tx_state_q == SPM_TX_ACTIVE) : gate_status;

	// ----------------------------------------
	// Link alarms
	// ----------------------------------------

	// Masked alarm sources merged onto one registered line.
	// Level, not sticky: a source that drops also drops the line.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link_alarm_irq_q <= 1'b0;
		end else begin
			link_alarm_irq_q <= |(link_alarm_src & link_alarm_irq_mask_q); // see R13
		end
	end

	assign link_alarm_irq = link_alarm_irq_q; // see R14
endmodule

// ==== spm_pkg.sv ====
// Constants and carrier types for the short-window power monitor.
// Assumes a byte-wide register port with 12-bit addresses on mclk.
package spm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] SPM_ADDR_LIMIT_LOW = 12'h588;
	localparam logic [11:0] SPM_ADDR_LIMIT_HIGH = 12'h589;
	localparam logic [11:0] SPM_ADDR_CONTROL = 12'h58a;
	localparam logic [11:0] SPM_ADDR_RESULT_LOW = 12'h58b;
	localparam logic [11:0] SPM_ADDR_RESULT_HIGH = 12'h58c;
	localparam logic [11:0] SPM_ADDR_TX_FSM = 12'h58d;
	localparam logic [11:0] SPM_ADDR_BLANKING = 12'h596;
	localparam logic [11:0] SPM_ADDR_MASK_LOW = 12'h597;
	localparam logic [11:0] SPM_ADDR_MASK_HIGH = 12'h598;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int SPM_CTRL_ENABLE_BIT = 7;
	localparam int SPM_LEN_W = 2;
	localparam int SPM_TX_FSM_ENABLE_BIT = 0;
	localparam int SPM_SOFT_VALUE_BIT = 3;
	localparam int SPM_SOFT_OVERRIDE_BIT = 2;
	localparam int SPM_HIGH_W = 5;
	localparam int SPM_POWER_W = 13;
	localparam int SPM_ALARM_W = 9;
	localparam logic [7:0] SPM_RESET_BYTE = 8'h00;
	localparam logic [7:0] SPM_UNMAPPED_BYTE = 8'h00;

	// ----------------------------------------
	// Datapath and timing constants
	// ----------------------------------------
	localparam int SPM_SAMPLE_W = 16;
	localparam int SPM_COARSE_W = 6;
	localparam int SPM_INTERP_W = 4;
	localparam int SPM_PERIOD_W = 8;
	localparam int SPM_MAIN_MULT = 4;
	localparam int SPM_CHAN_MULT = 8;
	localparam int SPM_PLAIN_PERIOD = 32;
	localparam int SPM_MAX_LEN = 3;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} spm_reg_req_s;

	typedef struct packed {
		logic [SPM_SAMPLE_W-1:0] i;
		logic [SPM_SAMPLE_W-1:0] q;
	} spm_iq_s;

	typedef enum logic [1:0] {
		SPM_TX_IDLE = 2'b00,
		SPM_TX_ACTIVE = 2'b01,
		SPM_TX_BLOCKED = 2'b11
	} spm_tx_state_e;

endpackage

// ==== spm_tick_gen.sv ====
// Power-detector clock tick generator for the short-window monitor.
// Assumes interpolation settings are static while the detector runs.
`timescale 1ns/1ns
module spm_tick_gen (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic [spm_pkg::SPM_INTERP_W-1:0] main_interp,
	input wire logic [spm_pkg::SPM_INTERP_W-1:0] chan_interp,
	// Tick out
	output logic tick
);
	import spm_pkg::*;

	logic [SPM_PERIOD_W-1:0] period;
	logic [SPM_PERIOD_W-1:0] count_q;

	// Period length in converter clocks, first matching case wins
	always_comb begin
		if (main_interp > 4'h1) begin
			period = SPM_PERIOD_W'(SPM_MAIN_MULT * main_interp); // see R3
		end else if (chan_interp > 4'h1) begin
			period = SPM_PERIOD_W'(SPM_CHAN_MULT * main_interp); // see R4
		end else begin
			period = SPM_PERIOD_W'(SPM_PLAIN_PERIOD); // see R5
		end
	end

	// Free count, restarted whenever the detector is off
	always_ff @(posedge mclk) begin
		if (!rst_n || !run || count_q >= period - 8'h01) begin
			count_q <= 8'h00;
		end else begin
			count_q <= count_q + 8'h01;
		end
	end

	assign tick = run && (count_q >= period - 8'h01);
endmodule

// ==== spm_power_avg.sv ====
// Squares coarse I/Q and averages over 2^len detector ticks.
// Assumes samples are two's complement and stable per converter clock.
`timescale 1ns/1ns
module spm_power_avg (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic tick,
	input wire logic [spm_pkg::SPM_LEN_W-1:0] win_len,
	input wire spm_pkg::spm_iq_s sample,
	// Result
	output logic [spm_pkg::SPM_POWER_W-1:0] avg_power,
	output logic avg_done
);
	import spm_pkg::*;

	logic signed [SPM_COARSE_W-1:0] i_c;
	logic signed [SPM_COARSE_W-1:0] q_c;
	logic [SPM_POWER_W-1:0] inst_power;
	logic [15:0] acc_q;
	logic [SPM_MAX_LEN-1:0] n_q;
	logic last;

	// Only the six top bits take part
	assign i_c = sample.i[SPM_SAMPLE_W-1 -: SPM_COARSE_W]; // see R6
	assign q_c = sample.q[SPM_SAMPLE_W-1 -: SPM_COARSE_W];
	assign inst_power = SPM_POWER_W'(i_c * i_c) + SPM_POWER_W'(q_c * q_c); // see R6
	assign last = (n_q == SPM_MAX_LEN'((4'h1 << win_len) - 4'h1)); // see R2

	// Window accumulation, one sample per tick
	always_ff @(posedge mclk) begin
		if (!rst_n || !run) begin
			acc_q <= 16'h0000;
			n_q <= '0;
		end else if (tick) begin
			acc_q <= last ? 16'h0000 : acc_q + 16'(inst_power);
			n_q <= last ? '0 : n_q + 1'b1;
		end
	end

	// Average is sum shifted down by the window exponent
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			avg_power <= '0;
			avg_done <= 1'b0;
		end else begin
			avg_done <= run && tick && last;
			if (run && tick && last) begin
				avg_power <= SPM_POWER_W'((acc_q + 16'(inst_power)) >> win_len); // see R2
			end
		end
	end
endmodule

// ==== spm_monitor_asserts.sv ====
// Port checker for the short-window power monitor.
// Assumes binding to spm_monitor; shadows the written controls.
`timescale 1ns/1ns
module spm_monitor_asserts #(
	parameter int PAGE_INDEX = 0,
	parameter int PAGE_COUNT = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire spm_pkg::spm_reg_req_s reg_req,
	input wire logic [PAGE_COUNT-1:0] main_converter_page_select,
	input wire logic [7:0] reg_rdata,
	// Gate and alarms
	input wire logic transmit_gate_input,
	input wire logic transmit_gate_status,
	input wire logic transmit_enable,
	input wire logic short_power_error,
	input wire logic [spm_pkg::SPM_ALARM_W-1:0] link_alarm_src,
	input wire logic link_alarm_irq
);
	import spm_pkg::*;
	logic sel, rd_ok, hit;
	logic en_q, fsm_q, ovr_q, val_q;
	logic [8:0] mask_q;
	assign sel = main_converter_page_select[PAGE_INDEX];
	assign rd_ok = reg_req.read && sel;
	assign hit = |(link_alarm_src & mask_q);
	// Shadow of paged control writes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			en_q <= 1'b0;
			fsm_q <= 1'b0;
			ovr_q <= 1'b0;
			val_q <= 1'b0;
			mask_q <= 9'h000;
		end else if (reg_req.write && sel) begin
			if (reg_req.addr == SPM_ADDR_CONTROL) en_q <= reg_req.wdata[7];
			if (reg_req.addr == SPM_ADDR_TX_FSM) fsm_q <= reg_req.wdata[0];
			if (reg_req.addr == SPM_ADDR_BLANKING) ovr_q <= reg_req.wdata[2];
			if (reg_req.addr == SPM_ADDR_BLANKING) val_q <= reg_req.wdata[3];
			if (reg_req.addr == SPM_ADDR_MASK_LOW) mask_q[7:0] <= reg_req.wdata;
			if (reg_req.addr == SPM_ADDR_MASK_HIGH) mask_q[8] <= reg_req.wdata[0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Gate, alarm and readback relations
	gate_override_a: assert property (transmit_gate_status == (ovr_q ? val_q : transmit_gate_input))
		else $error("gate status differs from override");
	fsm_off_a: assert property (!fsm_q |-> transmit_enable == transmit_gate_status)
		else $error("transmit enable differs from gate status");
	fsm_read_a: assert property (rd_ok && reg_req.addr == SPM_ADDR_TX_FSM |=> reg_rdata == {7'h00, $past(fsm_q)})
		else $error("fsm control readback wrong");
	alarm_mask_a: assert property ($past(rst_n) |-> link_alarm_irq == $past(hit))
		else $error("alarm output differs from masked sources");
	mask_read_a: assert property (rd_ok && reg_req.addr == SPM_ADDR_MASK_LOW |=> reg_rdata == $past(mask_q[7:0]))
		else $error("mask readback wrong");
	result_high_a: assert property (rd_ok && reg_req.addr == SPM_ADDR_RESULT_HIGH |=> reg_rdata[7:5] == 3'h0)
		else $error("result high reserved bits set");
	page_refuse_a: assert property (reg_req.read && !sel |=> $stable(reg_rdata))
		else $error("unpaged read changed data");
	error_off_a: assert property (!en_q [*2] |=> !short_power_error)
		else $error("error flag while disabled");
	error_en_a: assert property ($rose(short_power_error) |-> $past(en_q))
		else $error("error flag rose without enable");
	// Main scenarios reached
	cover property (short_power_error);
	cover property (link_alarm_irq);
	cover property (ovr_q && transmit_gate_status != transmit_gate_input);
endmodule

bind spm_monitor spm_monitor_asserts #(.PAGE_INDEX(PAGE_INDEX), .PAGE_COUNT(PAGE_COUNT)) spm_monitor_asserts_inst (
	.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .main_converter_page_select(main_converter_page_select),
	.reg_rdata(reg_rdata), .transmit_gate_input(transmit_gate_input), .transmit_gate_status(transmit_gate_status),
	.transmit_enable(transmit_enable), .short_power_error(short_power_error), .link_alarm_src(link_alarm_src),
	.link_alarm_irq(link_alarm_irq));

// ==== short_power_monitor_txen_ctrl_test.sv ====
// Self-checking bench for the short-window power monitor.
// Assumes spm_monitor acting on page bit 0 and a 25 MHz mclk.
`timescale 1ns/1ns
module short_power_monitor_txen_ctrl_test;
	import spm_pkg::*;
	logic mclk, rst_n, gate;
	spm_reg_req_s req;
	logic [1:0] page;
	logic [3:0] mi, ci;
	spm_iq_s smp;
	logic [8:0] src;
	logic [7:0] rdata, rd;
	logic tstat, ten, perr, irq;
	int bad_count, n_checks, cycles;
	logic [11:0] addrs [10] = '{12'h588, 12'h589, 12'h58a, 12'h58b, 12'h58c, 12'h58d, 12'h596, 12'h597, 12'h598, 12'h590};
	logic [7:0] keep [10] = '{8'hff, 8'h1f, 8'h83, 8'h00, 8'h00, 8'h01, 8'h0c, 8'hff, 8'h01, 8'h00};

	spm_monitor #(.PAGE_INDEX(0), .PAGE_COUNT(2)) spm_monitor_inst (
		.mclk(mclk), .rst_n(rst_n), .reg_req(req), .main_converter_page_select(page), .reg_rdata(rdata),
		.main_interp(mi), .chan_interp(ci), .sample(smp), .transmit_gate_input(gate),
		.transmit_gate_status(tstat), .transmit_enable(ten), .short_power_error(perr),
		.link_alarm_src(src), .link_alarm_irq(irq));

	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic check(string nm, logic [15:0] s, logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(negedge mclk);
		req = '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(negedge mclk);
		req.write = 1'b0;
	endtask

	task automatic rd_reg(logic [11:0] a);
		@(negedge mclk);
		req.addr = a;
		req.read = 1'b1;
		@(negedge mclk);
		req.read = 1'b0;
		rd = rdata;
	endtask

	task automatic test_regs();
		foreach (addrs[k]) begin
			rd_reg(addrs[k]);
			check("reset value", rd, 0);
		end
		foreach (addrs[k]) begin
			wr(addrs[k], 8'hff);
			rd_reg(addrs[k]);
			check("written value", rd, keep[k]);
			wr(addrs[k], 8'h00);
		end
		page = 2'b10;
		wr(SPM_ADDR_MASK_LOW, 8'h5a);
		rd_reg(SPM_ADDR_CONTROL);
		check("unpaged read", rd, 8'h00);
		page = 2'b01;
		rd_reg(SPM_ADDR_MASK_LOW);
		check("unpaged write", rd, 0);
		$display("test regs done, mismatches %0d", bad_count);
	endtask

	task automatic test_gate();
		for (int k = 0; k < 8; k++) begin
			wr(SPM_ADDR_BLANKING, {4'h0, k[2], k[1], 2'b00});
			gate = k[0];
			@(negedge mclk);
			check("gate status", tstat, k[1] ? k[2] : k[0]);
			check("transmit enable", ten, k[1] ? k[2] : k[0]);
		end
		wr(SPM_ADDR_BLANKING, 8'h00);
		wr(SPM_ADDR_TX_FSM, 8'h01);
		gate = 1'b0;
		repeat (3) @(negedge mclk);
		check("fsm idle", ten, 0);
		wr(SPM_ADDR_TX_FSM, 8'h00);
		$display("test gate done, mismatches %0d", bad_count);
	endtask

	task automatic test_alarm();
		for (int b = 0; b < 9; b++) begin
			wr(SPM_ADDR_MASK_LOW, 8'(9'h001 << b));
			wr(SPM_ADDR_MASK_HIGH, {7'h00, b == 8});
			src = ~(9'h001 << b);
			repeat (2) @(negedge mclk);
			check("alarm masked", irq, 0);
			src = 9'h001 << b;
			@(negedge mclk);
			check("alarm enabled", irq, 1);
		end
		src = 9'h000;
		$display("test alarm done, mismatches %0d", bad_count);
	endtask

	task automatic test_window(logic [3:0] m, logic [3:0] c, int len, int p);
		int n;
		wr(SPM_ADDR_CONTROL, 8'h00);
		mi = m;
		ci = c;
		wr(SPM_ADDR_CONTROL, 8'h80 | 8'(len));
		n = 0;
		while (perr !== 1'b1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		check("window length", 16'(n), 16'((p << len) + 1));
		rd_reg(SPM_ADDR_RESULT_LOW);
		check("result low", rd, 8'hc1);
		rd_reg(SPM_ADDR_RESULT_HIGH);
		check("result high", rd, 8'h07);
		$display("test window done, mismatches %0d", bad_count);
	endtask

	task automatic test_limit();
		wr(SPM_ADDR_CONTROL, 8'h00);
		mi = 4'h1;
		ci = 4'h1;
		repeat (2) @(negedge mclk);
		check("error disabled", perr, 0);
		wr(SPM_ADDR_LIMIT_LOW, 8'hc1);
		wr(SPM_ADDR_LIMIT_HIGH, 8'h07);
		wr(SPM_ADDR_CONTROL, 8'h80);
		repeat (40) @(negedge mclk);
		check("error at limit", perr, 0);
		wr(SPM_ADDR_LIMIT_LOW, 8'hc0);
		repeat (40) @(negedge mclk);
		check("error above limit", perr, 1);
		wr(SPM_ADDR_TX_FSM, 8'h01);
		gate = 1'b1;
		@(negedge mclk);
		check("fsm active", ten, 1);
		@(negedge mclk);
		check("fsm blocked", ten, 0);
		gate = 1'b0;
		wr(SPM_ADDR_TX_FSM, 8'h00);
		wr(SPM_ADDR_CONTROL, 8'h00);
		$display("test limit done, mismatches %0d", bad_count);
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		req = '0;
		page = 2'b01;
		mi = 4'h1;
		ci = 4'h1;
		smp = '{i: {6'h1f, 10'h3ff}, q: {6'h20, 10'h000}};
		gate = 1'b0;
		src = 9'h000;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		test_regs();
		test_gate();
		test_alarm();
		test_window(4'h1, 4'h1, 0, 32);
		test_window(4'h2, 4'h1, 1, 8);
		test_window(4'h1, 4'h2, 2, 8);
		test_window(4'h3, 4'h2, 3, 12);
		test_limit();
		print_verdict();
	end
endmodule
